// >>> rtl/ssh_pkg.sv
// Purpose: Shared constants and types for the sensor serial host port.
// Assumes: SPI mode 3 style framing, eight-bit bytes, six-bit register index.
// Notes: Both ends import this package; the interface does not.
package ssh_pkg;
	localparam int SSH_BYTE_W = 8;
	localparam int SSH_IDX_W = 6;
	localparam int SSH_BIT_CNT_W = 3;
	localparam logic [2:0] SSH_LAST_BIT = 3'h7;
	localparam int SSH_CMD_RW_POS = 7;
	localparam int SSH_CMD_HOLD_POS = 6;
	localparam logic [5:0] SSH_TWI_BASE = 6'h2C;
	localparam int SSH_REG_COUNT = 64;
	localparam logic [5:0] SSH_IFCFG_IDX = 6'h15;
	localparam int SSH_IFCFG_3W_POS = 0;
	localparam int SSH_IFCFG_PAR_POS = 1;
	localparam int SSH_IFCFG_TWI_DIS_POS = 2;
	localparam logic [7:0] SSH_IFCFG_RESET = 8'h00;
	localparam logic [7:0] SSH_FD_PREFIX = 8'h00;
	localparam logic [5:0] SSH_RO_FIRST = 6'h20;
	localparam logic [5:0] SSH_RO_LAST = 6'h25;
	localparam int SSH_DIV_HALF = 2;
	localparam int SSH_DIV_W = 4;
	typedef logic [7:0] ssh_byte_t;
	typedef logic [5:0] ssh_idx_t;

	function automatic logic ssh_parity(input ssh_idx_t idx);
		ssh_parity = ~(^idx);
	endfunction

	function automatic logic ssh_is_ro(input ssh_idx_t idx);
		ssh_is_ro = (idx >= SSH_RO_FIRST) && (idx <= SSH_RO_LAST);
	endfunction
endpackage

// >>> rtl/ssh_link_if.sv
// Purpose: Serial link between the host port device and its master.
// Assumes: Data pin shared in three-wire mode; enables are active low.
// Notes: Resolves the shared data wire from both enables.
`timescale 1ns/10ps
interface ssh_link_if;
	logic cs_n;
	logic sclk;
	logic mosi_o;
	logic mosi_oe_n;
	logic dev_sdio_o;
	logic dev_sdio_oe_n;
	logic miso_o;
	logic miso_oe_n;
	logic sdio;
	logic miso;

	always_comb begin
		if (!mosi_oe_n)
			sdio = mosi_o;
		else if (!dev_sdio_oe_n)
			sdio = dev_sdio_o;
		else
			sdio = 1'b1;
	end

	assign miso = !miso_oe_n ? miso_o : 1'b1;

	modport dev (
		input cs_n,
		input sclk,
		input sdio,
		output dev_sdio_o,
		output dev_sdio_oe_n,
		output miso_o,
		output miso_oe_n
	);

	modport host (
		output cs_n,
		output sclk,
		output mosi_o,
		output mosi_oe_n,
		input sdio,
		input miso
	);
endinterface

// >>> rtl/ssh_host.sv
// Purpose: Master end driving frames into the sensor serial host port.
// Assumes: User holds request data stable while busy is high.
// Notes: Link clock made here by dividing clk; idles high between frames.
`timescale 1ns/10ps
module ssh_host
	import ssh_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	ssh_link_if.host link,
	input wire logic req,
	input wire logic req_read,
	input wire logic req_hold,
	input wire logic [5:0] req_idx,
	input wire logic [2:0] req_len,
	input wire logic [7:0] wr_byte,
	input wire logic three_wire,
	output logic busy,
	output logic wr_take,
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	typedef enum logic [1:0] {SSH_H_IDLE, SSH_H_LOW, SSH_H_HIGH, SSH_H_END} ssh_h_state_e;
	ssh_h_state_e state;
	logic [SSH_DIV_W-1:0] div;
	logic [2:0] bitn;
	logic [2:0] left;
	logic cmd_phase;
	logic is_read;
	logic is_3w;
	logic [7:0] tx;
	logic [7:0] rx;
	logic miso_s1;
	logic miso_s2;
	logic sdio_s1;
	logic sdio_s2;
	logic in_bit;
	logic div_done;
	logic cap_pend;
	logic cap_last;

	assign div_done = (div == SSH_DIV_W'(SSH_DIV_HALF - 1));
	assign in_bit = is_3w ? sdio_s2 : miso_s2;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			miso_s1 <= 1'b1;
			miso_s2 <= 1'b1;
			sdio_s1 <= 1'b1;
			sdio_s2 <= 1'b1;
		end else begin
			miso_s1 <= link.miso;
			miso_s2 <= miso_s1;
			sdio_s1 <= link.sdio;
			sdio_s2 <= sdio_s1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			div <= '0;
		else if (state == SSH_H_IDLE || div_done)
			div <= '0;
		else
			div <= div + 1'b1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= SSH_H_IDLE;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b1;
			link.mosi_o <= 1'b1;
			link.mosi_oe_n <= 1'b1;
			busy <= 1'b0;
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			rd_byte <= '0;
			bitn <= '0;
			left <= '0;
			cmd_phase <= 1'b0;
			is_read <= 1'b0;
			is_3w <= 1'b0;
			tx <= '0;
			rx <= '0;
			cap_pend <= 1'b0;
			cap_last <= 1'b0;
		end else begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			// Sample one clk after the rise: the two-flop input lags the pin
			if (cap_pend) begin
				rx <= {rx[SSH_BYTE_W-2:0], in_bit};
				cap_pend <= 1'b0;
				if (cap_last) begin
					rd_valid <= 1'b1;
					rd_byte <= {rx[SSH_BYTE_W-2:0], in_bit};
				end
			end
			unique case (state)
				SSH_H_IDLE: begin
					link.sclk <= 1'b1;
					if (req) begin
						state <= SSH_H_LOW;
						busy <= 1'b1;
						link.cs_n <= 1'b0;
						is_read <= req_read;
						is_3w <= three_wire;
						left <= req_len;
						cmd_phase <= 1'b1;
						bitn <= '0;
						tx <= {req_read, req_hold, req_idx};
						link.mosi_oe_n <= 1'b0;
					end
				end
				SSH_H_LOW: if (div_done) begin
					link.sclk <= 1'b0;
					link.mosi_o <= tx[SSH_BYTE_W-1];
					tx <= {tx[SSH_BYTE_W-2:0], 1'b0};
					if (!cmd_phase && is_read && is_3w)
						link.mosi_oe_n <= 1'b1;
					state <= SSH_H_HIGH;
				end
				SSH_H_HIGH: if (div_done) begin
					link.sclk <= 1'b1;
					cap_pend <= 1'b1;
					cap_last <= (bitn == SSH_LAST_BIT) && !cmd_phase && is_read;
					bitn <= bitn + 1'b1;
					state <= SSH_H_LOW;
					if (bitn == SSH_LAST_BIT) begin
						if (!cmd_phase)
							left <= left - 1'b1;
						if (!is_read) begin
							tx <= wr_byte;
							wr_take <= 1'b1;
						end
						cmd_phase <= 1'b0;
						if (!cmd_phase && left == 3'h1)
							state <= SSH_H_END;
					end
				end
				SSH_H_END: if (div_done) begin
					link.cs_n <= 1'b1;
					link.mosi_oe_n <= 1'b1;
					busy <= 1'b0;
					state <= SSH_H_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> rtl/ssh_dev.sv
// Purpose: Device end of the sensor serial host port, SPI slave.
// Assumes: Link clock idles high; data sampled on rising, driven on falling.
// Notes: Register bank and two-wire strap live in the clk domain.
// Notes on behaviour
// - Two-wire slave address is 101100 plus strap
// - Address lowest bit from the strap pin
// - Two-wire slave only, never master
// - Frame is 16 pulses, plus 8 per extra byte
// - Bit 0 begins first falling after select
// - First bit: 0 write, 1 read
// - Second bit is hold or index parity
// - Hold 1 keeps index, 0 increments
// - Bits 2-7 carry register index
// - Data bits 8-15, MSB first
// - Three-wire bit; four-wire after reset
// - Eight bits out during command byte
// - Deselected: data-out held high impedance
// - Master idles clock before selecting
// - Burst continues until select rises
// - Full-duplex write sends zeros after command
// - Half-duplex: data-out off, data-in bidirectional
// - Software disables two-wire when sharing bus
// - Burst read drives next MSB on falling
// - Burst reads also in three-wire mode
// - Sensor data registers read-only, any time
// - Select high means two-wire until select first goes low, then SPI only
`timescale 1ns/10ps
module ssh_dev
	import ssh_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	ssh_link_if.dev link,
	input wire logic addr_lsb_strap,
	input wire logic [7:0] sensor_word,
	input wire logic sensor_load,
	output logic [6:0] twi_addr,
	output logic twi_mode,
	output logic three_wire,
	output logic parity_err,
	output logic wr_strobe,
	output logic [5:0] wr_idx,
	output logic [7:0] wr_data
);
	logic [7:0] bank [SSH_REG_COUNT];
	logic [7:0] interface_config_reg;
	// Link domain
	logic [2:0] bitn;
	logic cmd_done;
	logic is_read;
	logic addr_hold_bit;
	logic [5:0] idx;
	logic [7:0] shin;
	logic [7:0] shout;
	logic wr_tgl;
	logic [7:0] wr_hold_byte;
	logic [5:0] wr_hold_idx;
	logic perr_l;
	logic ld_req;
	logic cfg3_s1;
	logic cfg3_s2;
	logic cfgp_s1;
	logic cfgp_s2;
	logic rd_drive;
	logic [7:0] next_bits;
	// Clk domain
	logic tg_s1;
	logic tg_s2;
	logic tg_s3;
	logic cs_s1;
	logic cs_s2;
	logic perr_s1;
	logic perr_s2;
	logic cs_seen;

	assign next_bits = {shin[6:0], link.sdio};

	// Link domain settings synchronised; only changed between frames
	always_ff @(posedge link.sclk or negedge nrst) begin
		if (!nrst) begin
			cfg3_s1 <= 1'b0;
			cfg3_s2 <= 1'b0;
			cfgp_s1 <= 1'b0;
			cfgp_s2 <= 1'b0;
		end else begin
			cfg3_s1 <= interface_config_reg[SSH_IFCFG_3W_POS];
			cfg3_s2 <= cfg3_s1;
			cfgp_s1 <= interface_config_reg[SSH_IFCFG_PAR_POS];
			cfgp_s2 <= cfgp_s1;
		end
	end

	// Frame cleared by select high
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			bitn <= '0;
			cmd_done <= 1'b0;
			is_read <= 1'b0;
			addr_hold_bit <= 1'b0;
			idx <= '0;
			shin <= '0;
			perr_l <= 1'b0;
			ld_req <= 1'b0;
		end else begin
			shin <= {shin[6:0], link.sdio};
			bitn <= bitn + 1'b1;
			ld_req <= 1'b0;
			if (bitn == SSH_LAST_BIT) begin
				ld_req <= 1'b1;
				if (!cmd_done) begin
					cmd_done <= 1'b1;
					is_read <= next_bits[SSH_CMD_RW_POS];
					addr_hold_bit <= next_bits[SSH_CMD_HOLD_POS] & ~cfgp_s2;
					idx <= next_bits[SSH_IDX_W-1:0];
					if (cfgp_s2 && next_bits[SSH_CMD_HOLD_POS] != ssh_parity(next_bits[SSH_IDX_W-1:0]))
						perr_l <= 1'b1;
				end else if (!addr_hold_bit)
					idx <= idx + 1'b1;
			end
		end
	end

	// Write byte handed to clk domain by toggle
	always_ff @(posedge link.sclk or negedge nrst) begin
		if (!nrst) begin
			wr_tgl <= 1'b0;
			wr_hold_byte <= '0;
			wr_hold_idx <= '0;
		end else if (!link.cs_n && cmd_done && !is_read && bitn == SSH_LAST_BIT && !perr_l) begin
			wr_tgl <= ~wr_tgl;
			wr_hold_byte <= {shin[6:0], link.sdio};
			wr_hold_idx <= idx;
		end
	end

	// Output shifter on falling edge; bank read crosses by stable index
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			shout <= SSH_FD_PREFIX;
			rd_drive <= 1'b0;
		end else begin
			// Take the shared pin at bit 8, same edge the master lets go
			if (ld_req && is_read)
				rd_drive <= 1'b1;
			if (ld_req && is_read)
				shout <= bank[idx];
			else if (ld_req)
				shout <= SSH_FD_PREFIX;
			else
				shout <= {shout[6:0], 1'b0};
		end
	end

	// Pin drivers
	always_comb begin
		link.miso_o = shout[SSH_BYTE_W-1];
		link.miso_oe_n = link.cs_n | cfg3_s2;
		link.dev_sdio_o = shout[SSH_BYTE_W-1];
		link.dev_sdio_oe_n = link.cs_n | ~cfg3_s2 | ~is_read | ~rd_drive;
	end

	// Clk domain
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			perr_s1 <= 1'b0;
			perr_s2 <= 1'b0;
		end else begin
			tg_s1 <= wr_tgl;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
			cs_s1 <= link.cs_n;
			cs_s2 <= cs_s1;
			perr_s1 <= perr_l;
			perr_s2 <= perr_s1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			interface_config_reg <= SSH_IFCFG_RESET;
			wr_strobe <= 1'b0;
			wr_idx <= '0;
			wr_data <= '0;
			for (int i = 0; i < SSH_REG_COUNT; i++)
				bank[i] <= '0;
		end else begin
			wr_strobe <= 1'b0;
			if (sensor_load)
				bank[SSH_RO_FIRST] <= sensor_word;
			if (tg_s2 != tg_s3 && !ssh_is_ro(wr_hold_idx)) begin
				bank[wr_hold_idx] <= wr_hold_byte;
				wr_strobe <= 1'b1;
				wr_idx <= wr_hold_idx;
				wr_data <= wr_hold_byte;
				if (wr_hold_idx == SSH_IFCFG_IDX)
					interface_config_reg <= wr_hold_byte;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			twi_addr <= {SSH_TWI_BASE, 1'b0};
			twi_mode <= 1'b0;
			three_wire <= 1'b0;
			parity_err <= 1'b0;
			cs_seen <= 1'b0;
		end else begin
			twi_addr <= {SSH_TWI_BASE, addr_lsb_strap};
			if (!cs_s2)
				cs_seen <= 1'b1;
			twi_mode <= cs_s2 & ~cs_seen & ~interface_config_reg[SSH_IFCFG_TWI_DIS_POS];
			three_wire <= interface_config_reg[SSH_IFCFG_3W_POS];
			parity_err <= perr_s2;
		end
	end
endmodule

// >>> sim/ssh_link_asserts.sv
// Purpose: Link checks for the serial host port.
// Assumes: Sampled on clk; sclk half period is two clk.
// Notes: Counts sclk rises per frame.
`timescale 1ns/10ps
module ssh_link_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi_o,
	input wire logic mosi_oe_n,
	input wire logic dev_sdio_o,
	input wire logic dev_sdio_oe_n,
	input wire logic miso_o,
	input wire logic miso_oe_n,
	input wire logic sdio,
	input wire logic miso
);
	logic sclk_d;
	logic [7:0] rises;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sclk_d <= 1'b1;
		else
			sclk_d <= sclk;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rises <= 8'h00;
		else if (cs_n)
			rises <= 8'h00;
		else if (sclk && !sclk_d)
			rises <= rises + 8'h01;
	end
	desel_miso_off_a: assert property (cs_n && $past(cs_n) |-> miso_oe_n)
		else $error("miso driven while deselected");
	desel_sdio_off_a: assert property (cs_n && $past(cs_n) |-> dev_sdio_oe_n)
		else $error("sdio driven while deselected");
	idle_clock_high_a: assert property (cs_n |-> sclk)
		else $error("sclk not idle while deselected");
	frame_start_a: assert property ($fell(cs_n) |-> sclk ##[1:3] !sclk)
		else $error("first falling edge missing");
	pulse_count_a: assert property ($rose(cs_n) |-> rises >= 8'h10 && rises[2:0] == 3'h0)
		else $error("frame pulse count wrong");
	cmd_no_drive_a: assert property (!cs_n && rises < 8'h08 |-> dev_sdio_oe_n)
		else $error("device drove sdio in command byte");
	cmd_prefix_a: assert property (!cs_n && !miso_oe_n && rises inside {[8'h01:8'h07]} |-> !miso)
		else $error("command byte output not zero");
	no_contention_a: assert property (mosi_oe_n || dev_sdio_oe_n)
		else $error("both ends drive sdio");
	data_stable_a: assert property (!mosi_oe_n && $rose(sclk) |-> $stable(sdio))
		else $error("sdio moved at rising sclk");
endmodule

// >>> sim/sensor_serial_host_port_bench.sv
// Purpose: Bench joining host and device ends over the link.
// Assumes: Device bank stores written bytes.
// Notes: Frames driven through the host user side.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module sensor_serial_host_port_bench;
	logic clk = 0, nrst, req, req_read, req_hold, tw, busy, wr_take, rd_valid;
	logic strap, sensor_load, twi_mode, dev_tw, parity_err, wr_strobe, pe_seen;
	logic [5:0] req_idx, wr_idx;
	logic [2:0] req_len;
	logic [7:0] wr_byte, rd_byte, sensor_word, wr_data;
	logic [6:0] twi_addr;
	logic [5:0] wi[8];
	logic [7:0] wd[8], rx[8];
	int errors = 0, checks = 0, nw, nr;
	always #25 clk = ~clk;
	ssh_link_if link();
	ssh_host ssh_host_inst(.clk(clk), .nrst(nrst), .link(link), .req(req), .req_read(req_read),
		.req_hold(req_hold), .req_idx(req_idx), .req_len(req_len), .wr_byte(wr_byte),
		.three_wire(tw), .busy(busy), .wr_take(wr_take), .rd_valid(rd_valid), .rd_byte(rd_byte));
	ssh_dev ssh_dev_inst(.clk(clk), .nrst(nrst), .link(link), .addr_lsb_strap(strap),
		.sensor_word(sensor_word), .sensor_load(sensor_load), .twi_addr(twi_addr),
		.twi_mode(twi_mode), .three_wire(dev_tw), .parity_err(parity_err),
		.wr_strobe(wr_strobe), .wr_idx(wr_idx), .wr_data(wr_data));
	ssh_link_asserts ssh_link_asserts_inst(.clk(clk), .nrst(nrst), .cs_n(link.cs_n),
		.sclk(link.sclk), .mosi_o(link.mosi_o), .mosi_oe_n(link.mosi_oe_n),
		.dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe_n(link.dev_sdio_oe_n),
		.miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .sdio(link.sdio), .miso(link.miso));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic frame(input logic rd, hold, input logic [5:0] idx, input logic [2:0] len,
		input logic [7:0] b);
		int n, idle, bi;
		nw = 0;
		nr = 0;
		bi = 0;
		idle = 0;
		pe_seen = 1'b0;
		req_read = rd;
		req_hold = hold;
		req_idx = idx;
		req_len = len;
		wr_byte = b;
		req = 1'b1;
		@(posedge clk);
		#2 req = 1'b0;
		for (n = 0; idle < 8; n++) begin
			if (n == 3000) begin
				errors++;
				report_and_stop();
			end
			@(posedge clk);
			#2;
			idle = busy ? 0 : idle + 1;
			if (wr_take) begin
				bi++;
				wr_byte = 8'(b + 8'h11 * bi);
			end
			if (rd_valid)
				rx[nr++] = rd_byte;
			if (wr_strobe) begin
				wi[nw] = wr_idx;
				wd[nw++] = wr_data;
			end
			if (parity_err)
				pe_seen = 1'b1;
			if (!rd && !tw && !link.sclk && !link.cs_n) `CHK("miso", 1'b0, link.miso)
		end
	endtask
	initial begin
		nrst = 0;
		req = 0;
		req_read = 0;
		req_hold = 0;
		req_idx = 0;
		req_len = 1;
		wr_byte = 0;
		tw = 0;
		strap = 1;
		sensor_word = 0;
		sensor_load = 0;
		repeat (10) @(posedge clk);
		#2 nrst = 1;
		@(posedge clk);
		#2 `CHK("twi_addr", 7'h59, twi_addr)
		`CHK("twi_mode", 1'b1, twi_mode)
		`CHK("three_wire", 1'b0, dev_tw)
		strap = 0;
		repeat (3) @(posedge clk);
		#2 `CHK("twi_addr", 7'h58, twi_addr)
		frame(0, 0, 6'h05, 3, 8'hA1);
		`CHK("twi_mode", 1'b0, twi_mode)
		`CHK("nw", 3, nw)
		for (int k = 0; k < 3; k++) begin
			`CHK("wr_idx", 6'(6'h05 + k), wi[k])
			`CHK("wr_data", 8'(8'hA1 + 8'h11 * k), wd[k])
		end
		frame(1, 0, 6'h05, 3, 8'h00);
		`CHK("nr", 3, nr)
		for (int k = 0; k < 3; k++) `CHK("rd_byte", 8'(8'hA1 + 8'h11 * k), rx[k])
		frame(0, 1, 6'h08, 2, 8'h10);
		`CHK("wr_idx", 6'h08, wi[1])
		frame(1, 1, 6'h08, 2, 8'h00);
		for (int k = 0; k < 2; k++) `CHK("rd_byte", 8'h21, rx[k])
		sensor_word = 8'h5A;
		sensor_load = 1;
		@(posedge clk);
		#2 sensor_load = 0;
		frame(0, 0, 6'h20, 1, 8'hFF);
		`CHK("nw", 0, nw)
		frame(1, 0, 6'h20, 1, 8'h00);
		`CHK("rd_byte", 8'h5A, rx[0])
		frame(0, 0, 6'h15, 1, 8'h01);
		`CHK("three_wire", 1'b1, dev_tw)
		tw = 1;
		frame(1, 0, 6'h05, 2, 8'h00);
		for (int k = 0; k < 2; k++) `CHK("rd_byte", 8'(8'hA1 + 8'h11 * k), rx[k])
		frame(0, 0, 6'h15, 1, 8'h07);
		`CHK("twi_mode", 1'b0, twi_mode)
		frame(0, 1, 6'h0A, 1, 8'h77);
		`CHK("parity_err", 1'b0, pe_seen)
		frame(0, 0, 6'h0A, 1, 8'h88);
		`CHK("nw", 0, nw)
		`CHK("parity_err", 1'b1, pe_seen)
		frame(1, 1, 6'h0A, 1, 8'h00);
		`CHK("rd_byte", 8'h77, rx[0])
		report_and_stop();
	end
endmodule
